// >>> design/scm_pkg.sv
// constants for the serializer configuration and mode registers
package scm_pkg;
  localparam logic [7:0] GEN_CFG_OFS = 8'h03;
  localparam logic [7:0] MODE_SEL_OFS = 8'h04;
  localparam logic [7:0] GEN_CFG_RST = 8'hd2;
  localparam logic [7:0] MODE_SEL_RST = 8'h80;
  localparam logic [7:0] GEN_CFG_MASK = 8'hba;
  localparam logic [7:0] MODE_SEL_MASK = 8'ha0;
  localparam int GEN_CRC_EN_BIT = 7;
  localparam int GEN_AUTO_ACK_BIT = 5;
  localparam int GEN_FILTER_BIT = 4;
  localparam int GEN_PASS_BIT = 3;
  localparam int GEN_CLK_AUTO_BIT = 1;
  localparam int MODE_FAILSAFE_BIT = 7;
  localparam int MODE_CRC_CLR_BIT = 5;
  localparam int FILTER_CYCLES = 2;
  localparam int NUM_PORTS = 2;
  localparam int NUM_SYNC_IN = 3;
endpackage : scm_pkg

// >>> design/scm_config_regs.sv
// general configuration and mode select registers with the logic they steer
`timescale 1ns/1ns
module scm_config_regs #(
  parameter int NSYNC = scm_pkg::NUM_SYNC_IN
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register access from the serial control bus slave
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic second_port_select,
  // i2c bridging decisions
  input wire logic rw_req,
  input wire logic rw_is_write,
  input wire logic rw_port,
  input wire logic rw_to_des,
  input wire logic rw_alias_hit,
  input wire logic remote_ack,
  input wire logic remote_nack,
  output logic fwd_req,
  output logic local_ack,
  output logic local_nack,
  // sync inputs {vs, hs, de} and filtered copy
  input wire logic [NSYNC-1:0] sync_in,
  output logic [NSYNC-1:0] sync_out,
  // clock, crc and failsafe controls
  input wire logic tmds_clk_present,
  output logic use_int_osc,
  output logic crc_check_en,
  output logic crc_cnt_clear,
  output logic failsafe_low
);
  logic [7:0] gen_q;
  logic [7:0] gen_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [scm_pkg::NUM_PORTS-1:0] auto_ack_q;
  logic [scm_pkg::NUM_PORTS-1:0] pass_q;
  logic pend_auto_q;
  logic [7:0] rdata_d;
  logic [NSYNC-1:0] sync_hist_q;

  wire wr_gen = reg_wr && (reg_addr == scm_pkg::GEN_CFG_OFS);
  wire wr_mode = reg_wr && (reg_addr == scm_pkg::MODE_SEL_OFS);
  wire sel_port = second_port_select;
  wire auto_sel = auto_ack_q[sel_port];
  wire pass_sel = pass_q[sel_port];
  wire filter_en = gen_q[scm_pkg::GEN_FILTER_BIT];
  // the transaction's own port decides its handling
  wire req_auto = auto_ack_q[rw_port];
  wire req_pass = pass_q[rw_port];
  wire req_fwd = rw_req && (rw_to_des || (req_pass && rw_alias_hit));
  wire early_ack = req_fwd && rw_is_write && req_auto;
  wire waiting_remote = !pend_auto_q;

  // shared bits show the copy of the selected port
  wire [7:0] gen_view = (gen_q & ~((8'h01 << scm_pkg::GEN_AUTO_ACK_BIT)
                         | (8'h01 << scm_pkg::GEN_PASS_BIT)))
                        | ({7'h00, auto_sel} << scm_pkg::GEN_AUTO_ACK_BIT)
                        | ({7'h00, pass_sel} << scm_pkg::GEN_PASS_BIT);
  assign gen_d = wr_gen ? (reg_wdata & scm_pkg::GEN_CFG_MASK) : gen_q;
  assign mode_d = wr_mode ? (reg_wdata & scm_pkg::MODE_SEL_MASK) : mode_q;
  assign rdata_d = (reg_addr == scm_pkg::GEN_CFG_OFS) ? gen_view :
                   (reg_addr == scm_pkg::MODE_SEL_OFS) ? mode_q : 8'h00;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      // reserved bit 6 shows its reset value until the first write
      gen_q <= scm_pkg::GEN_CFG_RST;
      mode_q <= scm_pkg::MODE_SEL_RST;
      reg_rdata <= 8'h00;
    end else begin
      gen_q <= gen_d;
      mode_q <= mode_d;
      reg_rdata <= rdata_d;
    end
  end

  // per-port copies of auto-ack and pass-through
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      auto_ack_q <= '0;
      pass_q <= '0;
    end else if (wr_gen) begin
      auto_ack_q[sel_port] <= reg_wdata[scm_pkg::GEN_AUTO_ACK_BIT];
      pass_q[sel_port] <= reg_wdata[scm_pkg::GEN_PASS_BIT];
    end
  end

  // bridging answers to the local master
  // remote answers follow the mode latched at the last forwarded request
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pend_auto_q <= 1'b0;
      fwd_req <= 1'b0;
      local_ack <= 1'b0;
      local_nack <= 1'b0;
    end else begin
      if (req_fwd) begin
        pend_auto_q <= req_auto && rw_is_write;
      end
      fwd_req <= req_fwd;
      local_ack <= early_ack || (remote_ack && waiting_remote);
      local_nack <= remote_nack && waiting_remote;
    end
  end

  // two-clock glitch filter, one lane per sync input
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_filt
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          sync_hist_q[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          sync_hist_q[gi] <= sync_in[gi];
          if (!filter_en || (sync_in[gi] == sync_hist_q[gi])) begin
            sync_out[gi] <= sync_in[gi];
          end
        end
      end
      AST_FILTER_REJECT: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(filter_en) && $changed(sync_out[gi])
        |-> $past(sync_in[gi]) == $past(sync_in[gi], 2))
        else $error("filter passed a one-clock pulse");
      AST_FILTER_KEEP: assert property (@(posedge mclk) disable iff (!reset_n)
        filter_en && (sync_in[gi] == sync_hist_q[gi]) |=> sync_out[gi] == $past(sync_in[gi]))
        else $error("filter dropped a steady level");
      AST_FILTER_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
        !filter_en |=> sync_out[gi] == $past(sync_in[gi]))
        else $error("unfiltered input not passed on");
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      use_int_osc <= 1'b0;
      crc_check_en <= 1'b0;
      crc_cnt_clear <= 1'b0;
      failsafe_low <= 1'b0;
    end else begin
      use_int_osc <= gen_q[scm_pkg::GEN_CLK_AUTO_BIT] && !tmds_clk_present;
      crc_check_en <= gen_q[scm_pkg::GEN_CRC_EN_BIT];
      crc_cnt_clear <= mode_q[scm_pkg::MODE_CRC_CLR_BIT];
      failsafe_low <= mode_q[scm_pkg::MODE_FAILSAFE_BIT];
    end
  end

  AST_CRC_EN_FOLLOWS: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_gen |-> ##2 crc_check_en == $past(reg_wdata[scm_pkg::GEN_CRC_EN_BIT], 2))
    else $error("crc checker enable does not follow write");
  AST_AUTO_ACK_NOW: assert property (@(posedge mclk) disable iff (!reset_n)
    rw_req && rw_is_write && rw_to_des && req_auto |=> local_ack)
    else $error("auto ack not given at once");
  AST_NO_REMOTE_NACK: assert property (@(posedge mclk) disable iff (!reset_n)
    remote_nack && pend_auto_q |=> !local_nack)
    else $error("remote nack leaked in auto ack mode");
  AST_PASS_FWD: assert property (@(posedge mclk) disable iff (!reset_n)
    rw_req && req_pass && rw_alias_hit |=> fwd_req)
    else $error("alias match not forwarded");
  AST_PORT_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
    rw_req && !rw_to_des && !pass_q[rw_port] |=> !fwd_req)
    else $error("forward without pass-through on that port");
  AST_OSC_SWITCH: assert property (@(posedge mclk) disable iff (!reset_n)
    !tmds_clk_present && gen_q[scm_pkg::GEN_CLK_AUTO_BIT] |=> use_int_osc)
    else $error("no switch to internal oscillator");
  AST_FAILSAFE: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_mode |-> ##2 failsafe_low == $past(reg_wdata[scm_pkg::MODE_FAILSAFE_BIT], 2))
    else $error("failsafe level does not follow write");
  AST_CRC_CLR_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_q[scm_pkg::MODE_CRC_CLR_BIT] && !wr_mode |=> crc_cnt_clear [*2])
    else $error("crc clear bit cleared itself");
  AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_addr == scm_pkg::MODE_SEL_OFS |=> (reg_rdata & ~scm_pkg::MODE_SEL_MASK) == 8'h00)
    else $error("reserved bits read nonzero");

  // checks on register contents and level outputs
  AST_MODE_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    !wr_mode |=> mode_q == $past(mode_q))
    else $error("mode register changed without a write");
  AST_GEN_RSVD: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_gen |=> (gen_q & ~scm_pkg::GEN_CFG_MASK) == 8'h00)
    else $error("reserved config bits took written value");
  AST_CRC_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
    !gen_q[scm_pkg::GEN_CRC_EN_BIT] |=> !crc_check_en)
    else $error("crc checker enabled while bit clear");
  AST_OSC_STAY: assert property (@(posedge mclk) disable iff (!reset_n)
    tmds_clk_present || !gen_q[scm_pkg::GEN_CLK_AUTO_BIT] |=> !use_int_osc)
    else $error("internal oscillator chosen without cause");

  // checks on the bridging answers and forwards
  AST_REMOTE_ACK: assert property (@(posedge mclk) disable iff (!reset_n)
    remote_ack && waiting_remote |=> local_ack)
    else $error("remote ack not passed on");
  AST_NACK_PASS: assert property (@(posedge mclk) disable iff (!reset_n)
    remote_nack && waiting_remote |=> local_nack)
    else $error("remote nack not passed on");
  AST_NO_REMOTE_ACK: assert property (@(posedge mclk) disable iff (!reset_n)
    remote_ack && pend_auto_q && !early_ack |=> !local_ack)
    else $error("remote ack passed in auto ack mode");
  AST_LOCAL_ACK_SRC: assert property (@(posedge mclk) disable iff (!reset_n)
    local_ack |-> $past(early_ack) || $past(remote_ack))
    else $error("local ack without a cause");
  AST_LOCAL_NACK_SRC: assert property (@(posedge mclk) disable iff (!reset_n)
    local_nack |-> $past(remote_nack))
    else $error("local nack without a remote nack");
  AST_FWD_ONLY_REQ: assert property (@(posedge mclk) disable iff (!reset_n)
    !rw_req |=> !fwd_req)
    else $error("forward without a request");
endmodule : scm_config_regs

// >>> tb/scm_config_regs_tb.sv
// self-checking bench for the configuration and mode registers
`timescale 1ns/1ns
module scm_config_regs_tb;
  logic mclk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, second_port_select = 1'h0;
  logic rw_req = 1'h0, rw_is_write = 1'h0, rw_port = 1'h0, rw_to_des = 1'h0;
  logic rw_alias_hit = 1'h0, remote_ack = 1'h0, remote_nack = 1'h0, tmds_clk_present = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] sync_in = 3'h0, sync_out;
  logic fwd_req, local_ack, local_nack, use_int_osc, crc_check_en, crc_cnt_clear, failsafe_low;
  int mismatches = 0, cmp_count = 0;

  scm_config_regs dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .second_port_select(second_port_select),
    .rw_req(rw_req), .rw_is_write(rw_is_write), .rw_port(rw_port), .rw_to_des(rw_to_des),
    .rw_alias_hit(rw_alias_hit), .remote_ack(remote_ack), .remote_nack(remote_nack),
    .fwd_req(fwd_req), .local_ack(local_ack), .local_nack(local_nack), .sync_in(sync_in),
    .sync_out(sync_out), .tmds_clk_present(tmds_clk_present), .use_int_osc(use_int_osc),
    .crc_check_en(crc_check_en), .crc_cnt_clear(crc_cnt_clear), .failsafe_low(failsafe_low));

  initial forever #25 mclk = ~mclk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    cyc(2);
    chk(reg_rdata, exp);
  endtask : rd

  // one bridge request, ends with its answer cycle settled
  task automatic req(input logic p, input logic w, input logic d, input logic h);
    @(posedge mclk);
    {rw_req, rw_port, rw_is_write, rw_to_des, rw_alias_hit} <= {1'h1, p, w, d, h};
    @(posedge mclk);
    rw_req <= 1'h0;
    #1;
  endtask : req

  task automatic nack();
    @(posedge mclk);
    remote_nack <= 1'h1;
    @(posedge mclk);
    remote_nack <= 1'h0;
    #1;
  endtask : nack

  task automatic rack();
    @(posedge mclk);
    remote_ack <= 1'h1;
    @(posedge mclk);
    remote_ack <= 1'h0;
    #1;
  endtask : rack

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    cyc(2);
    chk(crc_check_en, 8'h01);
    chk(failsafe_low, 8'h01);
    chk(use_int_osc, 8'h01);
    @(posedge mclk) tmds_clk_present <= 1'h1;
    cyc(1);
    chk(use_int_osc, 8'h00);
    @(posedge mclk) tmds_clk_present <= 1'h0;
    rd(8'h03, 8'hd2);
    rd(8'h04, 8'h80);
    rd(8'h05, 8'h00);
    wr(8'h03, 8'hff);
    wr(8'h04, 8'hff);
    wr(8'h05, 8'hff);
    rd(8'h03, 8'hba);
    rd(8'h04, 8'ha0);
    chk(crc_cnt_clear, 8'h01);
    wr(8'h03, 8'h20);
    wr(8'h04, 8'h00);
    cyc(2);
    chk({crc_check_en, use_int_osc, crc_cnt_clear, failsafe_low}, 8'h00);
    $display("register test done");
    req(1'h0, 1'h1, 1'h1, 1'h0);
    chk({fwd_req, local_ack}, 8'h03);
    nack();
    chk(local_nack, 8'h00);
    rack();
    chk(local_ack, 8'h00);
    req(1'h0, 1'h0, 1'h1, 1'h0);
    chk({fwd_req, local_ack}, 8'h02);
    wr(8'h03, 8'h00);
    req(1'h0, 1'h1, 1'h1, 1'h0);
    chk({fwd_req, local_ack}, 8'h02);
    nack();
    chk(local_nack, 8'h01);
    rack();
    chk(local_ack, 8'h01);
    @(posedge mclk) second_port_select <= 1'h1;
    wr(8'h03, 8'h08);
    req(1'h1, 1'h0, 1'h0, 1'h1);
    chk(fwd_req, 8'h01);
    req(1'h0, 1'h0, 1'h0, 1'h1);
    chk(fwd_req, 8'h00);
    rd(8'h03, 8'h08);
    @(posedge mclk) second_port_select <= 1'h0;
    rd(8'h03, 8'h00);
    $display("bridge test done");
    wr(8'h03, 8'h10);
    cyc(2);
    @(posedge mclk) sync_in <= 3'h1;
    @(posedge mclk) sync_in <= 3'h0;
    #1;
    chk(sync_out, 8'h00);
    cyc(2);
    chk(sync_out, 8'h00);
    @(posedge mclk) sync_in <= 3'h7;
    cyc(2);
    chk(sync_out, 8'h07);
    wr(8'h03, 8'h00);
    @(posedge mclk) sync_in <= 3'h1;
    cyc(1);
    chk(sync_out, 8'h01);
    $display("filter test done");
    stop_test();
  end
endmodule : scm_config_regs_tb
